// >>> bmcsr_pkg.sv
// ============================================================
// shared constants of the bus management csr block
package bmcsr_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_SWAP_DATA = 8'h0C;
  localparam logic [7:0] OFS_SWAP_CMP  = 8'h10;
  localparam logic [7:0] OFS_SWAP_CTL  = 8'h14;
  localparam logic [7:0] OFS_ROM_HDR   = 8'h18;
  localparam logic [7:0] OFS_BUS_IDENT = 8'h1C;
  localparam logic [7:0] OFS_BUS_OPT   = 8'h20;
  localparam logic [7:0] OFS_INT_STAT  = 8'h24;
  localparam logic [7:0] OFS_INT_MASK  = 8'h28;
  localparam logic [7:0] OFS_HOST_CTL  = 8'h50;

  // swap control fields
  localparam int unsigned SWAP_DONE_BIT = 31;
  localparam int unsigned SEL_W         = 2;
  localparam logic [1:0]  SEL_RESET     = 2'h0;

  // csr resource select codes
  localparam logic [1:0] RES_BUS_MGR_ID = 2'h0;
  localparam logic [1:0] RES_BANDWIDTH  = 2'h1;
  localparam logic [1:0] RES_CHAN_HI    = 2'h2;
  localparam logic [1:0] RES_CHAN_LO    = 2'h3;

  // constant and reset values
  localparam logic [31:0] BUS_IDENT_VALUE = 32'h3133_3934;
  localparam logic [31:0] BUS_OPT_RESET   = 32'h0000_B003;
  localparam logic [31:0] BUS_OPT_WMASK   = 32'hF8FF_F0C0;
  localparam logic [31:0] ROM_HDR_RESET   = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

  // host control and interrupt fields
  localparam int unsigned LINK_ACT_BIT  = 17;
  localparam int unsigned INT_SWAP_BIT  = 0;
  localparam int unsigned INT_W         = 1;

  // axi4-lite answer codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    BMCSR_SEL_MGR,
    BMCSR_SEL_BW,
    BMCSR_SEL_HI,
    BMCSR_SEL_LO
  } bmcsr_sel_e;
endpackage : bmcsr_pkg

// >>> bmcsr_properties.sv
`timescale 1ns/100ps
// ============================================================
// port checker for the bus management csr register block
module bmcsr_properties
  import bmcsr_pkg::*;
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        srst,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  // link side view
  input wire logic        irq,
  input wire logic [31:0] romHeader,
  input wire logic [31:0] busIdent,
  input wire logic [31:0] busOptions
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [7:0] lastAr;
  // ============================================================
  // address of the read under way
  always_ff @(posedge clk_sys) begin
    if (s_axi_arvalid && s_axi_arready) begin
      lastAr <= s_axi_araddr;
    end
  end
  // reset state is checked while reset is applied, so no disable here
  property p_reset;
    @(posedge clk_sys) disable iff (1'b0)
      srst |=> busOptions == BUS_OPT_RESET && romHeader == ROM_HDR_RESET && !irq;
  endproperty
  // ============================================================
  // assertions
  a_ident_const: assert property (busIdent == BUS_IDENT_VALUE)
    else $error("bus ident output changed");
  a_opt_fixed: assert property ((busOptions & ~BUS_OPT_WMASK) == 32'h0000_0003)
    else $error("bus options constant bits wrong");
  a_reset_values: assert property (p_reset)
    else $error("reset values wrong");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_ctl_resv_zero: assert property (s_axi_rvalid && lastAr == OFS_SWAP_CTL |->
    s_axi_rdata[30:2] == 29'h0) else $error("control reserved bits not zero");
  a_ident_read: assert property (s_axi_rvalid && lastAr == OFS_BUS_IDENT |->
    s_axi_rdata == BUS_IDENT_VALUE) else $error("bus ident read wrong");
  // main scenarios
  c_ctl_read: cover property (s_axi_rvalid && lastAr == OFS_SWAP_CTL);
  c_irq_high: cover property ($rose(irq));
  c_write: cover property (s_axi_bvalid);
endmodule : bmcsr_properties

bind bmcsr_regs bmcsr_properties u_props (.clk_sys, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .irq, .romHeader, .busIdent, .busOptions);

// >>> bmcsr_regs.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
module bmcsr_regs #(
  parameter logic [31:0] INIT_MGR = 32'h0000_0000,
  parameter logic [31:0] INIT_BW  = 32'h0000_0000,
  parameter logic [31:0] INIT_HI  = 32'h0000_0000,
  parameter logic [31:0] INIT_LO  = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        srst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq,
  // config rom view toward the link
  output logic [31:0]      romHeader,
  output logic [31:0]      busIdent,
  output logic [31:0]      busOptions,
  output logic             linkActivate
);
  import bmcsr_pkg::*;

  // ============================================================
  // helpers

  // merge write data under byte strobes and a writable mask
  function automatic logic [31:0] strbMerge(
    input logic [31:0] oldWord,
    input logic [31:0] newWord,
    input logic [3:0]  strb,
    input logic [31:0] wmask
  );
    logic [31:0] laneMask;
    laneMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    laneMask = laneMask & wmask;
    return (oldWord & ~laneMask) | (newWord & laneMask);
  endfunction : strbMerge

  // true for any offset the block decodes
  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      OFS_SWAP_DATA, OFS_SWAP_CMP, OFS_SWAP_CTL, OFS_ROM_HDR,
      OFS_BUS_IDENT, OFS_BUS_OPT, OFS_INT_STAT, OFS_INT_MASK,
      OFS_HOST_CTL: return 1'b1;
      default:      return 1'b0;
    endcase
  endfunction : isMapped

  // ============================================================
  // register storage
  logic [31:0]      swapData;
  logic [31:0]      swapCompare;
  logic             swapDoneFlag;
  logic [SEL_W-1:0] swapResourceSelect;
  logic [31:0]      romHeaderReg;
  logic [31:0]      busOptReg;
  logic [INT_W-1:0] intStatus;
  logic [INT_W-1:0] intMask;
  logic             linkActReg;

  // write channel state
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  logic        awHeld;
  logic        wHeld;
  logic        wrFire;

  // swap engine hookup
  logic        swapStart;
  logic        swapDone;
  logic [31:0] swapOld;

  // read decode
  logic [31:0] next_rdata;
  logic        rdFire;

  // ============================================================
  // write address and data capture, either order
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awHeld        <= 1'b0;
      wrAddr        <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld        <= 1'b1;
      wrAddr        <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      awHeld        <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wHeld        <= 1'b0;
      wrData       <= WORD_ZERO;
      wrStrb       <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld        <= 1'b1;
      wrData       <= s_axi_wdata;
      wrStrb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wHeld        <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // the write lands once both halves are held
  assign wrFire = awHeld && wHeld && !s_axi_bvalid;

  // write response, decode error on unmapped offsets
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= isMapped(wrAddr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ============================================================
  // compare-swap operand registers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      swapCompare <= WORD_ZERO;
    end else if (wrFire && wrAddr == OFS_SWAP_CMP) begin
      swapCompare <= strbMerge(swapCompare, wrData, wrStrb, '1);
    end
  end

  // data register returns the old resource after each swap
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      swapData <= WORD_ZERO;
    end else if (swapDone) begin
      swapData <= swapOld;
    end else if (wrFire && wrAddr == OFS_SWAP_DATA) begin
      swapData <= strbMerge(swapData, wrData, wrStrb, '1);
    end
  end

  // ============================================================
  // swap control: select field and done flag
  assign swapStart = wrFire && (wrAddr == OFS_SWAP_CTL);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      swapResourceSelect <= SEL_RESET;
    end else if (swapStart && wrStrb[0]) begin
      swapResourceSelect <= wrData[SEL_W-1:0];
    end
  end

  // completion sets, any control write clears; set wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      swapDoneFlag <= 1'b1;
    end else if (swapDone) begin
      swapDoneFlag <= 1'b1;
    end else if (swapStart) begin
      swapDoneFlag <= 1'b0;
    end
  end

  // select reaches the engine with the start strobe
  bmcsr_swap_unit #(
    .INIT_MGR (INIT_MGR),
    .INIT_BW  (INIT_BW),
    .INIT_HI  (INIT_HI),
    .INIT_LO  (INIT_LO)
  ) u_swap (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .start    (swapStart),
    .sel      (wrStrb[0] ? wrData[SEL_W-1:0] : swapResourceSelect),
    .cmpValue (swapCompare),
    .newValue (swapData),
    .done     (swapDone),
    .oldValue (swapOld)
  );

  // ============================================================
  // config rom header, always writable by software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      romHeaderReg <= ROM_HDR_RESET;
    end else if (wrFire && wrAddr == OFS_ROM_HDR) begin
      // lengths and crc must be valid before activation
      romHeaderReg <= strbMerge(romHeaderReg, wrData, wrStrb, '1);
    end
  end

  // bus options, only the capability fields take writes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busOptReg <= BUS_OPT_RESET;
    end else if (wrFire && wrAddr == OFS_BUS_OPT) begin
      busOptReg <= strbMerge(busOptReg, wrData, wrStrb, BUS_OPT_WMASK);
    end
  end

  // host control: link activate
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      linkActReg <= 1'b0;
    end else if (wrFire && wrAddr == OFS_HOST_CTL && wrStrb[LINK_ACT_BIT / 8]) begin
      linkActReg <= wrData[LINK_ACT_BIT];
    end
  end

  // ============================================================
  // interrupt status and mask
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      intMask <= '0;
    end else if (wrFire && wrAddr == OFS_INT_MASK && wrStrb[0]) begin
      intMask <= wrData[INT_W-1:0];
    end
  end

  // sticky on completion, cleared by a read; set wins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      intStatus <= '0;
    end else if (swapDone) begin
      intStatus[INT_SWAP_BIT] <= 1'b1;
    end else if (rdFire && s_axi_araddr == OFS_INT_STAT) begin
      intStatus <= '0;
    end
  end

  // registered level interrupt
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStatus & intMask);
    end
  end

  // ============================================================
  // read path
  assign rdFire = s_axi_arvalid && s_axi_arready;

  // read multiplexer
  always_comb begin
    next_rdata = WORD_ZERO;
    case (s_axi_araddr)
      OFS_SWAP_DATA: next_rdata = swapData;
      OFS_SWAP_CMP:  next_rdata = swapCompare;
      OFS_SWAP_CTL: begin
        next_rdata[SWAP_DONE_BIT]  = swapDoneFlag;
        next_rdata[SEL_W-1:0]      = swapResourceSelect; // bits 30-2 zero
      end
      OFS_ROM_HDR:   next_rdata = romHeaderReg;
      OFS_BUS_IDENT: next_rdata = BUS_IDENT_VALUE;
      OFS_BUS_OPT:   next_rdata = busOptReg;
      OFS_INT_STAT:  next_rdata[INT_W-1:0] = intStatus;
      OFS_INT_MASK:  next_rdata[INT_W-1:0] = intMask;
      OFS_HOST_CTL:  next_rdata[LINK_ACT_BIT] = linkActReg;
      default:       next_rdata = WORD_ZERO;
    endcase
  end

  // one read in flight; address refused while data waits
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= WORD_ZERO;
      s_axi_rresp   <= RESP_OKAY;
    end else if (rdFire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ============================================================
  // config rom quadlets seen by remote nodes, and link activate
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      romHeader    <= ROM_HDR_RESET;
      busIdent     <= BUS_IDENT_VALUE;
      busOptions   <= BUS_OPT_RESET;
      linkActivate <= 1'b0;
    end else begin
      romHeader    <= romHeaderReg; // first rom quadlet
      busIdent     <= BUS_IDENT_VALUE; // first info quadlet
      busOptions   <= busOptReg; // second info quadlet
      linkActivate <= linkActReg;
    end
  end
endmodule : bmcsr_regs

// >>> bmcsr_swap_unit.sv
`timescale 1ns/100ps
// ============================================================
// compare-swap engine over the four bus management resources
module bmcsr_swap_unit #(
  parameter logic [31:0] INIT_MGR = 32'h0000_0000,
  parameter logic [31:0] INIT_BW  = 32'h0000_0000,
  parameter logic [31:0] INIT_HI  = 32'h0000_0000,
  parameter logic [31:0] INIT_LO  = 32'h0000_0000
) (
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  // operation request
  input  wire logic                     start,
  input  wire logic [bmcsr_pkg::SEL_W-1:0] sel,
  input  wire logic [31:0]              cmpValue,
  input  wire logic [31:0]              newValue,
  // operation result
  output logic                          done,
  output logic [31:0]                   oldValue
);
  import bmcsr_pkg::*;

  logic [31:0] resource [4];

  // ============================================================
  // resource storage and the swap itself
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      resource[RES_BUS_MGR_ID] <= INIT_MGR;
      resource[RES_BANDWIDTH]  <= INIT_BW;
      resource[RES_CHAN_HI]    <= INIT_HI;
      resource[RES_CHAN_LO]    <= INIT_LO;
    end else if (start && (resource[sel] == cmpValue)) begin
      resource[sel] <= newValue; // replace only on match
    end
  end

  // old value comes back one cycle after start
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done     <= 1'b0;
      oldValue <= WORD_ZERO;
    end else begin
      done <= start; // finished in one cycle
      if (start) begin
        oldValue <= resource[sel];
      end
    end
  end
endmodule : bmcsr_swap_unit

// >>> bus_mgmt_csr_swap_and_bus_info_tb_top.sv
`timescale 1ns/100ps
// ============================================================
// self-checking bench for the csr register block
module bus_mgmt_csr_swap_and_bus_info_tb_top;
  import bmcsr_pkg::*;
  logic clk_sys, srst = 1, awv = 0, wv = 0, arv = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, d, res [4], nv, cv, v;
  logic [1:0] rsp, s;
  logic [3:0] ws = 4'hF;
  wire awr, wRdy, bv, arr, rv, irq, linkAct;
  wire [1:0] br, rr;
  wire [31:0] rdat, romH, bId, bOpt;
  int errors = 0, n_compared = 0, i;
  logic [7:0] ra [9] = '{OFS_SWAP_DATA, OFS_SWAP_CMP, OFS_SWAP_CTL, OFS_ROM_HDR,
    OFS_BUS_IDENT, OFS_BUS_OPT, OFS_INT_STAT, OFS_INT_MASK, OFS_HOST_CTL};
  logic [31:0] rvl [9] = '{WORD_ZERO, WORD_ZERO, 32'h8000_0000, ROM_HDR_RESET,
    BUS_IDENT_VALUE, BUS_OPT_RESET, WORD_ZERO, WORD_ZERO, WORD_ZERO};
  // ============================================================
  // design under test, response ready held high throughout
  bmcsr_regs DUT (.clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wRdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1), .irq(irq),
    .romHeader(romH), .busIdent(bId), .busOptions(bOpt), .linkActivate(linkAct));
  // clock of 40 ns period
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ============================================================
  // comparison and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // control read-back: done set, reserved bits zero, select in bits 1-0
  function automatic logic [31:0] ctlExp(input logic [1:0] sl);
    return {1'b1, 29'h0, sl};
  endfunction : ctlExp
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awa <= a;
    wd <= dat;
    awv <= 1;
    wv <= 1;
    while (!(ta && tw)) begin
      @(posedge clk_sys);
      if (awv && awr) begin
        ta = 1;
        awv <= 0;
      end
      if (wv && wRdy) begin
        tw = 1;
        wv <= 0;
      end
    end
    do @(posedge clk_sys); while (!bv);
    rsp = br;
    @(posedge clk_sys);
  endtask : wr
  // read: address held until taken, data taken at the valid edge
  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1;
    do @(posedge clk_sys); while (!arr);
    arv <= 0;
    do @(posedge clk_sys); while (!rv);
    d = rdat;
    rsp = rr;
    @(posedge clk_sys);
  endtask : rd
  // ============================================================
  // hang guard
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  // main sequence
  initial begin
    void'($urandom(32'h317F));
    for (i = 0; i < 4; i++) res[i] = WORD_ZERO;
    repeat (8) @(posedge clk_sys);
    srst <= 0;
    for (i = 0; i < 9; i++) begin
      rd(ra[i]);
      chk(d, rvl[i]);
    end
    // swaps over every resource, match random at first, forced later
    for (i = 0; i < 12; i++) begin
      s = i[1:0];
      nv = $urandom;
      cv = (i >= 4 || $urandom_range(1)) ? res[s] : ~res[s];
      wr(OFS_SWAP_DATA, nv);
      wr(OFS_SWAP_CMP, cv);
      rd(OFS_SWAP_CMP);
      chk(d, cv);
      wr(OFS_SWAP_CTL, ($urandom & 32'hFFFF_FFFC) | {30'h0, s});
      rd(OFS_SWAP_CTL);
      chk(d, ctlExp(s));
      rd(OFS_SWAP_DATA);
      chk(d, res[s]);
      if (cv === res[s]) res[s] = nv;
    end
    // masked event keeps irq low, status reads once then clears
    chk({31'h0, irq}, 32'h0);
    rd(OFS_INT_STAT);
    chk(d, 32'h1);
    rd(OFS_INT_STAT);
    chk(d, 32'h0);
    wr(OFS_INT_MASK, 32'h1);
    wr(OFS_SWAP_CTL, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_INT_STAT);
    chk(d, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    // control write without byte lane 0 keeps the old select
    ws <= 4'h0;
    wr(OFS_SWAP_CTL, 32'h0000_0003);
    ws <= 4'hF;
    rd(OFS_SWAP_CTL);
    chk(d, ctlExp(2'h0));
    // rom header, link activate, bus options, ident, unmapped place
    v = $urandom;
    wr(OFS_ROM_HDR, v);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd(OFS_ROM_HDR);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
    chk(d, v);
    chk(romH, v);
    wr(OFS_HOST_CTL, 32'h0002_0000);
    chk({31'h0, linkAct}, 32'h1);
    wr(OFS_BUS_OPT, 32'hFFFF_FFFF);
    rd(OFS_BUS_OPT);
    chk(d, 32'hF8FF_F0C3);
    chk(bOpt, 32'hF8FF_F0C3);
    wr(OFS_BUS_IDENT, 32'h0);
    rd(OFS_BUS_IDENT);
    chk(d, BUS_IDENT_VALUE);
    chk(bId, BUS_IDENT_VALUE);
    wr(8'h40, 32'hFFFF_FFFF);
    chk({30'h0, rsp}, {30'h0, RESP_DECERR});
    rd(8'h40);
    chk({30'h0, rsp}, {30'h0, RESP_DECERR});
    complete_run();
  end
endmodule : bus_mgmt_csr_swap_and_bus_info_tb_top
